// ### core/sbp_consts.vh
`ifndef SBP_CONSTS_VH
`define SBP_CONSTS_VH

// Register addresses (4-bit)
`define SBP_ADDR_SELF_ID 4'h4
`define SBP_ADDR_EVT_CTRL 4'h5
`define SBP_ADDR_RSVD_SIX 4'h6
`define SBP_ADDR_PAGE_PORT 4'h7
`define SBP_ADDR_PORT_LINE 4'h8
`define SBP_ADDR_PORT_SPEED 4'h9

// Self-identification field positions
`define SBP_SID_LINK_CTRL 0
`define SBP_SID_CONTENDER 1
`define SBP_SID_JITTER_LO 2
`define SBP_SID_PWR_LO 5
`define SBP_JITTER_VALUE 3'h0

// Event and control field positions
`define SBP_EC_WATCHDOG 0
`define SBP_EC_SHORT_RST 1
`define SBP_EC_LOOP 2
`define SBP_EC_PWR_FAIL 3
`define SBP_EC_TIMEOUT 4
`define SBP_EC_PORT_EVENT 5
`define SBP_EC_ACCEL 6
`define SBP_EC_MULTI 7
`define SBP_EC_RESET 8'h08

// Page/port selection
`define SBP_PAGE_PORT_STATUS 3'h0
`define SBP_PAGE_PORT_RESET 8'h00

// Port speed register field positions
`define SBP_PS_INT_EN 3
`define SBP_PS_FAULT 4

// Line state codes
`define SBP_LINE_Z 2'h3
`define SBP_LINE_ONE 2'h1
`define SBP_LINE_ZERO 2'h2
`define SBP_LINE_INVALID 2'h0

`endif

// ### core/sbp_config_status_regs.v
// What this block does
// - Contender bit loaded from bus clock strap
// - Jitter field always reads 000b
// - Power class drives self-ID packet field
// - Power class loaded from three supply straps
// - Watchdog reports status even when link idle
// - Watchdog sends resume interrupt on any port
// - Short reset request self-clears when finished
// - Loop flag set on loop, write-one clears
// - Power fail flag on supply fall, resets one
// - Arbitration timeout flag, write-one clears
// - Enabled port changes set port event flag
// - Resume with watchdog sets port event flag
// - Acceleration enable gates fast arbitration
// - Concatenation enable selects per-packet speed
// - Page select chooses upper register page
// - Port select chooses port status registers
// - Line states reported as two-bit codes
// - Child bit cleared on bus reset, tree-ID sets
// - Connected bit follows attached node detection
// - Bias bit follows cable bias detection
// - Disable bit disables the port
// - Peer speed cleared by bus reset, self-ID sets
// - Fault flag on suspend/resume error, write-one clears
`timescale 1ns/1ns
`include "sbp_consts.vh"

module sbp_config_status_regs #(
    parameter NUM_PORTS = 2,
    parameter PORT_SEL_W = 4
) (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // Straps
    input wire bus_clock_on_strap_i,
    input wire supply_select_strap_low_i,
    input wire supply_select_strap_mid_i,
    input wire supply_select_strap_high_i,
    // Register access from link controller
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [3:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    output reg reg_rvalid_o,
    // Core state and events
    input wire link_active_i,
    input wire cable_supply_present_i,
    input wire loop_detected_i,
    input wire arb_timeout_i,
    input wire short_reset_done_i,
    input wire bus_reset_i,
    input wire [NUM_PORTS-1:0] tree_id_done_i,
    input wire [NUM_PORTS-1:0] tree_child_i,
    input wire [NUM_PORTS-1:0] self_id_done_i,
    input wire [3*NUM_PORTS-1:0] self_id_speed_i,
    input wire [2*NUM_PORTS-1:0] tpa_state_i,
    input wire [2*NUM_PORTS-1:0] tpb_state_i,
    input wire [NUM_PORTS-1:0] port_connected_i,
    input wire [NUM_PORTS-1:0] port_bias_i,
    input wire [NUM_PORTS-1:0] resume_start_i,
    input wire [NUM_PORTS-1:0] suspend_fault_i,
    // Control outputs to core
    output reg contender_o,
    output reg [2:0] power_class_o,
    output reg short_reset_req_o,
    output reg accel_enable_o,
    output reg multi_speed_enable_o,
    output reg [NUM_PORTS-1:0] port_disable_o,
    output reg status_report_o,
    output reg [2:0] status_bits_o,
    output reg resume_irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    reg straps_taken;
    reg link_ctrl;
    reg watchdog;
    reg loop_flag;
    reg pwr_fail;
    reg timeout_flag;
    reg port_event;
    reg [2:0] page_sel;
    reg [PORT_SEL_W-1:0] port_sel;
    reg supply_prev;
    reg [NUM_PORTS-1:0] child;
    reg [NUM_PORTS-1:0] int_en;
    reg [NUM_PORTS-1:0] fault;
    reg [NUM_PORTS-1:0] conn_prev;
    reg [NUM_PORTS-1:0] bias_prev;
    reg [NUM_PORTS-1:0] dis_prev;
    reg [NUM_PORTS-1:0] fault_prev;
    reg [3*NUM_PORTS-1:0] peer_speed;

    wire wr_ec = reg_wr_i && (reg_addr_i == `SBP_ADDR_EVT_CTRL);
    wire wr_sid = reg_wr_i && (reg_addr_i == `SBP_ADDR_SELF_ID);
    wire wr_pp = reg_wr_i && (reg_addr_i == `SBP_ADDR_PAGE_PORT);
    wire port_page = (page_sel == `SBP_PAGE_PORT_STATUS);
    wire sel_ok = (port_sel < NUM_PORTS);

    function port_hit;
        input [PORT_SEL_W-1:0] sel;
        input integer idx;
        input [3:0] addr;
        input [3:0] target;
        begin
            port_hit = (addr == target) && (sel == idx[PORT_SEL_W-1:0]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Self-identification and event/control

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            straps_taken <= 1'b0;
            link_ctrl <= 1'b1;
            contender_o <= 1'b0;
            power_class_o <= 3'h0;
            watchdog <= 1'b0;
            short_reset_req_o <= 1'b0;
            loop_flag <= 1'b0;
            pwr_fail <= 1'b1;
            timeout_flag <= 1'b0;
            accel_enable_o <= 1'b0;
            multi_speed_enable_o <= 1'b0;
            page_sel <= 3'h0;
            port_sel <= {PORT_SEL_W{1'b0}};
            supply_prev <= 1'b0;
        end else begin
            supply_prev <= cable_supply_present_i;
            if (!straps_taken) begin
                straps_taken <= 1'b1;
                contender_o <= bus_clock_on_strap_i;
                power_class_o <= {supply_select_strap_high_i, supply_select_strap_mid_i,
                                  supply_select_strap_low_i};
            end else if (wr_sid) begin
                contender_o <= reg_wdata_i[`SBP_SID_CONTENDER];
                power_class_o <= reg_wdata_i[`SBP_SID_PWR_LO +: 3];
            end
            if (bus_reset_i)
                link_ctrl <= 1'b1;
            else if (wr_sid)
                link_ctrl <= reg_wdata_i[`SBP_SID_LINK_CTRL];
            if (wr_ec) begin
                watchdog <= reg_wdata_i[`SBP_EC_WATCHDOG];
                accel_enable_o <= reg_wdata_i[`SBP_EC_ACCEL];
                multi_speed_enable_o <= reg_wdata_i[`SBP_EC_MULTI];
            end
            if (short_reset_done_i)
                short_reset_req_o <= 1'b0;
            else if (wr_ec && reg_wdata_i[`SBP_EC_SHORT_RST])
                short_reset_req_o <= 1'b1;
            if (loop_detected_i)
                loop_flag <= 1'b1;
            else if (wr_ec && reg_wdata_i[`SBP_EC_LOOP])
                loop_flag <= 1'b0;
            if (supply_prev && !cable_supply_present_i)
                pwr_fail <= 1'b1;
            else if (wr_ec && reg_wdata_i[`SBP_EC_PWR_FAIL])
                pwr_fail <= 1'b0;
            if (arb_timeout_i)
                timeout_flag <= 1'b1;
            else if (wr_ec && reg_wdata_i[`SBP_EC_TIMEOUT])
                timeout_flag <= 1'b0;
            if (wr_pp) begin
                page_sel <= reg_wdata_i[2:0];
                port_sel <= reg_wdata_i[4 +: PORT_SEL_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-port status

    wire [NUM_PORTS-1:0] port_change;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
            wire wr_line = reg_wr_i && port_page && port_hit(port_sel, gi, reg_addr_i, `SBP_ADDR_PORT_LINE);
            wire wr_spd = reg_wr_i && port_page && port_hit(port_sel, gi, reg_addr_i, `SBP_ADDR_PORT_SPEED);
            assign port_change[gi] = int_en[gi] && ((conn_prev[gi] ^ port_connected_i[gi]) ||
                (bias_prev[gi] ^ port_bias_i[gi]) || (dis_prev[gi] ^ port_disable_o[gi]) ||
                (fault_prev[gi] ^ fault[gi]));
            always @(posedge core_clk_i) begin
                if (rst_i) begin
                    child[gi] <= 1'b0;
                    int_en[gi] <= 1'b0;
                    fault[gi] <= 1'b0;
                    port_disable_o[gi] <= 1'b0;
                    conn_prev[gi] <= 1'b0;
                    bias_prev[gi] <= 1'b0;
                    dis_prev[gi] <= 1'b0;
                    fault_prev[gi] <= 1'b0;
                    peer_speed[3*gi +: 3] <= 3'h0;
                end else begin
                    conn_prev[gi] <= port_connected_i[gi];
                    bias_prev[gi] <= port_bias_i[gi];
                    dis_prev[gi] <= port_disable_o[gi];
                    fault_prev[gi] <= fault[gi];
                    if (bus_reset_i)
                        child[gi] <= 1'b0;
                    else if (tree_id_done_i[gi])
                        child[gi] <= tree_child_i[gi];
                    if (bus_reset_i)
                        peer_speed[3*gi +: 3] <= 3'h0;
                    else if (self_id_done_i[gi])
                        peer_speed[3*gi +: 3] <= self_id_speed_i[3*gi +: 3];
                    if (wr_line)
                        port_disable_o[gi] <= reg_wdata_i[7];
                    if (wr_spd)
                        int_en[gi] <= reg_wdata_i[`SBP_PS_INT_EN];
                    if (suspend_fault_i[gi])
                        fault[gi] <= 1'b1;
                    else if (wr_spd && reg_wdata_i[`SBP_PS_FAULT])
                        fault[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Port event, watchdog reporting

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            port_event <= 1'b0;
            status_report_o <= 1'b0;
            status_bits_o <= 3'h0;
            resume_irq_o <= 1'b0;
        end else begin
            if ((|port_change) || (watchdog && (|resume_start_i)))
                port_event <= 1'b1;
            else if (wr_ec && reg_wdata_i[`SBP_EC_PORT_EVENT])
                port_event <= 1'b0;
            status_report_o <= watchdog || link_active_i;
            status_bits_o <= {timeout_flag, pwr_fail, loop_flag};
            resume_irq_o <= watchdog && (|resume_start_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    integer pi;
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            `SBP_ADDR_SELF_ID: next_rdata = {power_class_o, `SBP_JITTER_VALUE, contender_o, link_ctrl};
            `SBP_ADDR_EVT_CTRL: next_rdata = {multi_speed_enable_o, accel_enable_o, port_event, timeout_flag,
                                               pwr_fail, loop_flag, short_reset_req_o, watchdog};
            `SBP_ADDR_PAGE_PORT: next_rdata = {port_sel, 1'b0, page_sel};
            `SBP_ADDR_PORT_LINE: begin
                for (pi = 0; pi < NUM_PORTS; pi = pi + 1)
                    if (port_page && sel_ok && port_sel == pi[PORT_SEL_W-1:0])
                        next_rdata = {port_disable_o[pi], port_bias_i[pi], port_connected_i[pi], child[pi],
                                      tpb_state_i[2*pi +: 2], tpa_state_i[2*pi +: 2]};
            end
            `SBP_ADDR_PORT_SPEED: begin
                for (pi = 0; pi < NUM_PORTS; pi = pi + 1)
                    if (port_page && sel_ok && port_sel == pi[PORT_SEL_W-1:0])
                        next_rdata = {3'h0, fault[pi], int_en[pi], peer_speed[3*pi +: 3]};
            end
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
                reg_rdata_o <= next_rdata;
        end
    end

endmodule

// ### verif/sbp_link_model.sv
`timescale 1ns/1ns
module sbp_link_model (
    // Clock
    input wire core_clk_i,
    // Register bus towards the block
    output reg wr_o = 1'b0,
    output reg rd_o = 1'b0,
    output reg [3:0] addr_o = 4'h0,
    output reg [7:0] wdata_o = 8'h00,
    input wire [7:0] rdata_i,
    input wire rvalid_i
);
////////////////////////////////////////////////////////////
task wr(input [3:0] a, input [7:0] d);
    begin
        @(negedge core_clk_i);
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(negedge core_clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    end
endtask
// Answer is registered at the taking edge and sampled half a cycle later, at the next falling edge
task rd(input [3:0] a, output [7:0] d, output ok);
    begin
        @(negedge core_clk_i);
        rd_o = 1'b1;
        addr_o = a;
        @(negedge core_clk_i);
        rd_o = 1'b0;
        ok = rvalid_i === 1'b1;
        d = rdata_i;
    end
endtask
endmodule

// ### verif/sbp_regs_monitor.sv
`timescale 1ns/1ns
module sbp_regs_monitor #(
    parameter NUM_PORTS = 2
) (
    // Clock, reset, straps
    input wire core_clk_i,
    input wire rst_i,
    input wire bus_clock_on_strap_i,
    input wire supply_select_strap_low_i,
    input wire supply_select_strap_mid_i,
    input wire supply_select_strap_high_i,
    // Register bus
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [3:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    input wire reg_rvalid_o,
    // Core side
    input wire short_reset_done_i,
    input wire [NUM_PORTS-1:0] resume_start_i,
    input wire contender_o,
    input wire [2:0] power_class_o,
    input wire short_reset_req_o,
    input wire accel_enable_o,
    input wire multi_speed_enable_o,
    input wire status_report_o,
    input wire resume_irq_o
);
default clocking cb @(posedge core_clk_i);
endclocking
default disable iff (rst_i);
////////////////////////////////////////////////////////////
chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
chk_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("stray read answer");
chk_jitter_zero: assert property (reg_rd_i && reg_addr_i == 4'h4 |=> reg_rdata_o[4:2] == 3'h0)
    else $error("jitter field not zero");
chk_rsvd_zero: assert property (reg_rd_i && reg_addr_i == 4'h6 |=> reg_rdata_o == 8'h00)
    else $error("reserved register not zero");
chk_strap_load: assert property ($fell(rst_i) |=> contender_o == $past(bus_clock_on_strap_i)
    && power_class_o == $past({supply_select_strap_high_i, supply_select_strap_mid_i, supply_select_strap_low_i}))
    else $error("straps not captured");
chk_class_write: assert property (reg_wr_i && reg_addr_i == 4'h4 && !$past(rst_i)
    |=> power_class_o == $past(reg_wdata_i[7:5])) else $error("power class not written");
chk_sbr_start: assert property (reg_wr_i && reg_addr_i == 4'h5 && reg_wdata_i[1] && !short_reset_done_i
    |=> short_reset_req_o) else $error("short reset not requested");
chk_sbr_done: assert property (short_reset_done_i |=> !short_reset_req_o) else $error("short reset stuck");
chk_accel_write: assert property (reg_wr_i && reg_addr_i == 4'h5
    |=> {multi_speed_enable_o, accel_enable_o} == $past(reg_wdata_i[7:6])) else $error("enables not written");
chk_watch_report: assert property (reg_wr_i && reg_addr_i == 4'h5 && reg_wdata_i[0]
    |=> ##1 status_report_o) else $error("status not reported");
chk_irq_cause: assert property (resume_irq_o |-> $past(resume_start_i) != 0) else $error("stray resume irq");
cover property (resume_irq_o);
cover property (short_reset_req_o ##1 !short_reset_req_o);
cover property (reg_rvalid_o && reg_rdata_o != 8'h00);
endmodule
bind sbp_config_status_regs sbp_regs_monitor #(.NUM_PORTS(NUM_PORTS)) u_mon (.core_clk_i, .rst_i,
    .bus_clock_on_strap_i, .supply_select_strap_low_i, .supply_select_strap_mid_i, .supply_select_strap_high_i,
    .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .short_reset_done_i,
    .resume_start_i, .contender_o, .power_class_o, .short_reset_req_o, .accel_enable_o, .multi_speed_enable_o,
    .status_report_o, .resume_irq_o);

// ### verif/tb.sv
`timescale 1ns/1ns
module tb;
reg core_clk_i = 1'b0;
reg rst_i = 1'b1;
reg [3:0] strap = 4'h0;
reg link_active_i = 1'b0;
reg cable_supply_present_i = 1'b1;
reg loop_detected_i = 1'b0;
reg arb_timeout_i = 1'b0;
reg short_reset_done_i = 1'b0;
reg bus_reset_i = 1'b0;
reg [1:0] tree_id_done_i = 2'h0;
reg [1:0] tree_child_i = 2'h0;
reg [1:0] self_id_done_i = 2'h0;
reg [5:0] self_id_speed_i = 6'h00;
reg [3:0] tpa_state_i = 4'h0;
reg [3:0] tpb_state_i = 4'h0;
reg [1:0] port_connected_i = 2'h0;
reg [1:0] port_bias_i = 2'h0;
reg [1:0] resume_start_i = 2'h0;
reg [1:0] suspend_fault_i = 2'h0;
wire reg_wr_i, reg_rd_i, reg_rvalid_o, contender_o, short_reset_req_o, accel_enable_o, multi_speed_enable_o;
wire status_report_o, resume_irq_o;
wire [3:0] reg_addr_i;
wire [7:0] reg_wdata_i, reg_rdata_o;
wire [2:0] power_class_o, status_bits_o;
wire [1:0] port_disable_o;
integer errors = 0;
integer checks_done = 0;
integer i;
reg [7:0] seed, ev, r;
reg [7:0] p [0:1];
always #2 core_clk_i = ~core_clk_i;
sbp_config_status_regs #(.NUM_PORTS(2), .PORT_SEL_W(4)) i_dut (
    .core_clk_i, .rst_i, .bus_clock_on_strap_i(strap[3]), .supply_select_strap_low_i(strap[0]),
    .supply_select_strap_mid_i(strap[1]), .supply_select_strap_high_i(strap[2]), .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .link_active_i, .cable_supply_present_i,
    .loop_detected_i, .arb_timeout_i, .short_reset_done_i, .bus_reset_i, .tree_id_done_i, .tree_child_i,
    .self_id_done_i, .self_id_speed_i, .tpa_state_i, .tpb_state_i, .port_connected_i, .port_bias_i,
    .resume_start_i, .suspend_fault_i, .contender_o, .power_class_o, .short_reset_req_o, .accel_enable_o,
    .multi_speed_enable_o, .port_disable_o, .status_report_o, .status_bits_o, .resume_irq_o);
sbp_link_model u_lnk (.core_clk_i, .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o));
////////////////////////////////////////////////////////////
function [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
endfunction
task tick(input integer n);
    repeat (n) @(negedge core_clk_i);
endtask
task conclude;
    begin
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    end
endtask
task chk(input [7:0] seen, input [7:0] want);
    begin
        checks_done = checks_done + 1;
        if (seen !== want) begin
            errors = errors + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, want);
        end
    end
endtask
task rdc(input [3:0] a, input [7:0] want);
    reg ok;
    begin
        u_lnk.rd(a, r, ok);
        if (!ok) begin
            errors = errors + 1;
            conclude;
        end else begin
            chk(r, want);
        end
    end
endtask
////////////////////////////////////////////////////////////
initial begin
    seed = lfsr(8'h2c);
    strap = seed[3:0];
    tick(4);
    rst_i = 1'b0;
    tick(2);
    rdc(4'h4, {strap[2:0], 3'h0, strap[3], 1'b1});
    rdc(4'h5, 8'h08);
    u_lnk.wr(4'h6, 8'hff);
    rdc(4'h6, 8'h00);
    u_lnk.wr(4'h4, 8'hbe);
    rdc(4'h4, 8'ha2);
    chk({5'h00, power_class_o}, 8'h05);
    u_lnk.wr(4'h5, 8'hc9);
    ev = 8'hc1;
    chk({6'h00, multi_speed_enable_o, accel_enable_o}, 8'h03);
    loop_detected_i = 1'b1;
    arb_timeout_i = 1'b1;
    tick(1);
    loop_detected_i = 1'b0;
    arb_timeout_i = 1'b0;
    ev = ev | 8'h14;
    rdc(4'h5, ev);
    chk({status_report_o, status_bits_o}, 8'h0d);
    u_lnk.wr(4'h5, 8'hc1);
    rdc(4'h5, ev);
    // Loop event held across its own clearing write
    loop_detected_i = 1'b1;
    u_lnk.wr(4'h5, 8'hd5);
    loop_detected_i = 1'b0;
    ev = 8'hc5;
    rdc(4'h5, ev);
    u_lnk.wr(4'h5, 8'hc5);
    cable_supply_present_i = 1'b0;
    tick(3);
    ev = 8'hc9;
    rdc(4'h5, ev);
    resume_start_i = 2'h2;
    tick(1);
    resume_start_i = 2'h0;
    chk({7'h00, resume_irq_o}, 8'h01);
    rdc(4'h5, ev | 8'h20);
    u_lnk.wr(4'h5, 8'h2a);
    chk({6'h00, multi_speed_enable_o, accel_enable_o}, 8'h00);
    chk({7'h00, short_reset_req_o}, 8'h01);
    short_reset_done_i = 1'b1;
    tick(1);
    short_reset_done_i = 1'b0;
    rdc(4'h5, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
        u_lnk.wr(4'h7, {i[3:0], 4'h0});
        seed = lfsr(seed);
        tpa_state_i[2*i +: 2] = seed[1:0];
        tpb_state_i[2*i +: 2] = seed[3:2];
        port_connected_i[i] = seed[4];
        port_bias_i[i] = seed[5];
        p[i] = {1'b0, seed[5:4], 1'b0, seed[3:0]};
        tick(2);
        rdc(4'h8, p[i]);
    end
    tree_child_i = 2'h2;
    tree_id_done_i = 2'h2;
    self_id_speed_i = 6'h08;
    self_id_done_i = 2'h2;
    tick(1);
    tree_id_done_i = 2'h0;
    self_id_done_i = 2'h0;
    rdc(4'h8, p[1] | 8'h10);
    rdc(4'h9, 8'h01);
    bus_reset_i = 1'b1;
    tick(1);
    bus_reset_i = 1'b0;
    rdc(4'h8, p[1]);
    rdc(4'h9, 8'h00);
    u_lnk.wr(4'h8, 8'hff);
    chk({6'h00, port_disable_o}, 8'h02);
    rdc(4'h8, p[1] | 8'h80);
    u_lnk.wr(4'h7, 8'h20);
    rdc(4'h8, 8'h00);
    u_lnk.wr(4'h7, 8'h01);
    rdc(4'h8, 8'h00);
    u_lnk.wr(4'h7, 8'h00);
    u_lnk.wr(4'h9, 8'hf8);
    rdc(4'h9, 8'h08);
    port_bias_i[0] = ~port_bias_i[0];
    tick(3);
    rdc(4'h5, 8'h20);
    conclude;
end
endmodule
